// ==== tap_map.vh ====
// constants of the sram test access port
`ifndef TAP_MAP_VH
`define TAP_MAP_VH
`define IR_WIDTH        3
`define IR_EXTEST       3'h0
`define IR_IDCODE       3'h1
`define IR_SAMPLE_Z     3'h2
`define IR_SAMPLE       3'h4
`define IR_BYPASS       3'h7
`define IR_CAPTURE_PAT  3'h1
`define ID_WIDTH        32
`define BS_WIDTH        109
`define TLR_ONES        3'h5
`define ST_TLR          4'h0
`define ST_RTI          4'h1
`define ST_SEL_DR       4'h2
`define ST_CAP_DR       4'h3
`define ST_SHF_DR       4'h4
`define ST_EX1_DR       4'h5
`define ST_PAU_DR       4'h6
`define ST_EX2_DR       4'h7
`define ST_UPD_DR       4'h8
`define ST_SEL_IR       4'h9
`define ST_CAP_IR       4'hA
`define ST_SHF_IR       4'hB
`define ST_EX1_IR       4'hC
`define ST_PAU_IR       4'hD
`define ST_EX2_IR       4'hE
`define ST_UPD_IR       4'hF
`endif

// ==== sync2.v ====
// two flip-flop synchroniser for one level
`default_nettype none
module sync2 #(
  parameter RST_VAL = 1'b1
) (
  input  wire sys_clk,   // system clock
  input  wire rst,       // synchronous reset
  input  wire d,         // asynchronous level
  output wire q          // synchronised level
);
  reg meta_r;
  reg q_r;
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end
  assign q = q_r;
endmodule
`default_nettype wire

// ==== sram_boundary_scan_tap.v ====
// test access port controller with instruction, bypass, id and boundary registers
// Contract
// - all test inputs are sampled on the rising test clock edge
// - serial output changes only on the falling test clock edge
// - mode select steers the controller state machine
// - one serial register sits between data in and out, chosen by state and instruction
// - mode select high on five rising edges forces test-logic-reset
// - controller starts in reset at power-up without test clock
// - unconnected mode select or data input reads as one
// - identification instruction loads at power-up and on reset state entry
// - bypass instruction puts single bypass bit in the shift path
// - output-floating sample forces outputs high-z and captures pad inputs
`default_nettype none
`include "tap_map.vh"
module sram_boundary_scan_tap #(
  parameter ID_VALUE = 32'h0000_1235   // arbitrary identification value
) (
  input  wire                 sys_clk,     // system clock 200 MHz
  input  wire                 rst,         // synchronous reset, power-up
  input  wire                 tck,         // test clock pin
  input  wire                 tms,         // mode select pin
  input  wire                 tms_oe,      // high when the tester drives mode select
  input  wire                 tdi,         // serial data pin
  input  wire                 tdi_oe,      // high when the tester drives serial data
  output wire                 tdo,         // serial data out
  output wire                 tdo_oe,      // high while the output drives
  input  wire [`BS_WIDTH-1:0] pad_in,      // memory pad states to capture
  output wire [`BS_WIDTH-1:0] bs_out,      // boundary update latches
  output wire                 outputs_hiz, // forces memory outputs off
  output wire                 extest_en,   // boundary drives pads
  output wire [3:0]           tap_state    // controller state
);
  // pins and their drive enables are synchronised before any logic looks at them
  wire tck_s;
  wire tms_raw_s;
  wire tms_oe_s;
  wire tdi_raw_s;
  wire tdi_oe_s;
  sync2 #(.RST_VAL(1'b0)) u_tck    (.sys_clk(sys_clk), .rst(rst), .d(tck),    .q(tck_s));
  sync2 #(.RST_VAL(1'b1)) u_tms    (.sys_clk(sys_clk), .rst(rst), .d(tms),    .q(tms_raw_s));
  sync2 #(.RST_VAL(1'b0)) u_tms_oe (.sys_clk(sys_clk), .rst(rst), .d(tms_oe), .q(tms_oe_s));
  sync2 #(.RST_VAL(1'b1)) u_tdi    (.sys_clk(sys_clk), .rst(rst), .d(tdi),    .q(tdi_raw_s));
  sync2 #(.RST_VAL(1'b0)) u_tdi_oe (.sys_clk(sys_clk), .rst(rst), .d(tdi_oe), .q(tdi_oe_s));
  // floating pins read as one, as an internal pull-up would make them
  wire tms_s = tms_oe_s ? tms_raw_s : 1'b1;
  wire tdi_s = tdi_oe_s ? tdi_raw_s : 1'b1;

  reg                  tck_d_r;
  reg [3:0]            st_r;
  reg [3:0]            st_nxt;
  reg [2:0]            ones_r;
  reg [`IR_WIDTH-1:0]  ir_r;
  reg [`IR_WIDTH-1:0]  irs_r;
  reg                  byp_r;
  reg [`ID_WIDTH-1:0]  id_r;
  wire [`BS_WIDTH-1:0] bs_cells;
  wire [`BS_WIDTH-1:0] bs_latch;
  reg                  tdo_r;
  reg                  oe_r;
  reg                  sdo;

  wire rise = tck_s & ~tck_d_r;
  wire fall = ~tck_s & tck_d_r;

  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      `ST_TLR:    st_nxt = tms_s ? `ST_TLR    : `ST_RTI;
      `ST_RTI:    st_nxt = tms_s ? `ST_SEL_DR : `ST_RTI;
      `ST_SEL_DR: st_nxt = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR: st_nxt = tms_s ? `ST_EX1_DR : `ST_SHF_DR;
      `ST_SHF_DR: st_nxt = tms_s ? `ST_EX1_DR : `ST_SHF_DR;
      `ST_EX1_DR: st_nxt = tms_s ? `ST_UPD_DR : `ST_PAU_DR;
      `ST_PAU_DR: st_nxt = tms_s ? `ST_EX2_DR : `ST_PAU_DR;
      `ST_EX2_DR: st_nxt = tms_s ? `ST_UPD_DR : `ST_SHF_DR;
      `ST_UPD_DR: st_nxt = tms_s ? `ST_SEL_DR : `ST_RTI;
      `ST_SEL_IR: st_nxt = tms_s ? `ST_TLR    : `ST_CAP_IR;
      `ST_CAP_IR: st_nxt = tms_s ? `ST_EX1_IR : `ST_SHF_IR;
      `ST_SHF_IR: st_nxt = tms_s ? `ST_EX1_IR : `ST_SHF_IR;
      `ST_EX1_IR: st_nxt = tms_s ? `ST_UPD_IR : `ST_PAU_IR;
      `ST_PAU_IR: st_nxt = tms_s ? `ST_EX2_IR : `ST_PAU_IR;
      `ST_EX2_IR: st_nxt = tms_s ? `ST_UPD_IR : `ST_SHF_IR;
      `ST_UPD_IR: st_nxt = tms_s ? `ST_SEL_DR : `ST_RTI;
      default:    st_nxt = `ST_TLR;
    endcase
    // fifth consecutive high sample always lands in reset
    if (tms_s && ones_r >= (`TLR_ONES - 3'h1))
      st_nxt = `ST_TLR;
  end

  // serial path selection from state and instruction
  always @*
  begin
    sdo = byp_r;
    if (st_r == `ST_SHF_IR)
      sdo = irs_r[0];
    else
      case (ir_r)
        `IR_IDCODE:                         sdo = id_r[0];
        `IR_EXTEST, `IR_SAMPLE_Z, `IR_SAMPLE: sdo = bs_cells[0];
        default:                            sdo = byp_r;
      endcase
  end

  wire sel_id = (ir_r == `IR_IDCODE);
  wire sel_bs = (ir_r == `IR_EXTEST) || (ir_r == `IR_SAMPLE_Z) || (ir_r == `IR_SAMPLE);

  // edge detector idles low like the pin, so reset leaves no false edge
  always @(posedge sys_clk)
  begin
    if (rst)
      tck_d_r <= 1'b0;
    else
      tck_d_r <= tck_s;
  end

  // controller state and run of consecutive high mode samples
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r   <= `ST_TLR;
      ones_r <= 3'h0;
    end
    else if (rise)
    begin
      st_r   <= st_nxt;
      ones_r <= tms_s ? ((ones_r == 3'h7) ? ones_r : ones_r + 3'h1) : 3'h0;
    end
  end

  // instruction shift stage and active instruction
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ir_r  <= `IR_IDCODE;
      irs_r <= `IR_CAPTURE_PAT;
    end
    else if (rise)
    begin
      case (st_r)
        `ST_CAP_IR: irs_r <= `IR_CAPTURE_PAT;
        `ST_SHF_IR: irs_r <= {tdi_s, irs_r[`IR_WIDTH-1:1]};
        `ST_UPD_IR: ir_r  <= irs_r;
        default:    irs_r <= irs_r;
      endcase
      // identification is active from the very edge that enters reset, not one later
      if (st_nxt == `ST_TLR)
        ir_r <= `IR_IDCODE;
    end
  end

  // bypass and identification registers
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      byp_r <= 1'b0;
      id_r  <= {`ID_WIDTH{1'b0}};
    end
    else if (rise)
    begin
      if (st_r == `ST_CAP_DR)
      begin
        byp_r <= 1'b0;
        if (sel_id)
          id_r <= ID_VALUE;
      end
      else if (st_r == `ST_SHF_DR)
      begin
        if (sel_id)
          id_r <= {tdi_s, id_r[`ID_WIDTH-1:1]};
        else if (!sel_bs)
          byp_r <= tdi_s;
      end
    end
  end

  // one boundary cell per pad: synchronised capture, shift toward data out, update latch
  wire [`BS_WIDTH-1:0] pad_s;
  wire [`BS_WIDTH-1:0] bs_shf = {tdi_s, bs_cells[`BS_WIDTH-1:1]};
  genvar gi;
  generate
    for (gi = 0; gi < `BS_WIDTH; gi = gi + 1)
    begin : g_cell
      reg cell_r;
      reg latch_r;
      sync2 #(.RST_VAL(1'b0)) u_pad (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (pad_in[gi]),
        .q       (pad_s[gi])
      );
      always @(posedge sys_clk)
      begin
        if (rst)
        begin
          cell_r  <= 1'b0;
          latch_r <= 1'b0;
        end
        else if (rise && sel_bs)
        begin
          if (st_r == `ST_CAP_DR)
            cell_r <= pad_s[gi];
          else if (st_r == `ST_SHF_DR)
            cell_r <= bs_shf[gi];
          else if (st_r == `ST_UPD_DR)
            latch_r <= cell_r;
        end
      end
      assign bs_cells[gi] = cell_r;
      assign bs_latch[gi] = latch_r;
    end
  endgenerate

  // serial output and its enable move only after a falling test clock edge
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      tdo_r <= 1'b0;
      oe_r  <= 1'b0;
    end
    else if (fall)
    begin
      tdo_r <= sdo;
      oe_r  <= (st_r == `ST_SHF_DR) || (st_r == `ST_SHF_IR);
    end
  end

  assign tdo         = tdo_r;
  assign tdo_oe      = oe_r;
  assign bs_out      = bs_latch;
  assign outputs_hiz = (ir_r == `IR_SAMPLE_Z);
  assign extest_en   = (ir_r == `IR_EXTEST);
  assign tap_state   = st_r;
endmodule
`default_nettype wire

// ==== tap_checker.sv ====
// assertions on the test access port outputs
`default_nettype none
`include "tap_map.vh"
module tap_checker (
  input wire logic                 sys_clk,     // clock
  input wire logic                 rst,         // reset
  input wire logic                 tck,         // test clock
  input wire logic                 tdo,         // serial out
  input wire logic                 tdo_oe,      // out enable
  input wire logic [`BS_WIDTH-1:0] bs_out,      // latches
  input wire logic                 outputs_hiz, // outputs off
  input wire logic [3:0]           tap_state    // state
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_rst; disable iff (1'h0) rst |=> tap_state == `ST_TLR && !tdo_oe; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_tdo; $changed(tdo) |-> !tck; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved with tck high");
  property p_st; $changed(tap_state) |-> tck; endproperty
  a_st: assert property (p_st) else $error("state moved with tck low");
  property p_tlr; $changed(tap_state) && $past(tap_state) == `ST_TLR |-> tap_state == `ST_RTI;
  endproperty
  a_tlr: assert property (p_tlr) else $error("bad exit from reset");
  property p_cap; $past(tap_state) == `ST_CAP_DR && $changed(tap_state)
    |-> tap_state inside {`ST_SHF_DR, `ST_EX1_DR}; endproperty
  a_cap: assert property (p_cap) else $error("bad exit from capture");
  property p_ir; $changed(outputs_hiz) |-> $past(tap_state) == `ST_UPD_IR || tap_state == `ST_TLR;
  endproperty
  a_ir: assert property (p_ir) else $error("instruction moved");
  property p_bs; $changed(bs_out) |-> $past(tap_state) == `ST_UPD_DR; endproperty
  a_bs: assert property (p_bs) else $error("latch moved");
  property p_oe; $rose(tdo_oe) |-> tap_state inside {`ST_SHF_DR, `ST_SHF_IR}; endproperty
  a_oe: assert property (p_oe) else $error("tdo driven outside shift");
  c_shf: cover property (tap_state == `ST_SHF_DR);
  c_hiz: cover property (outputs_hiz);
  c_upd: cover property ($changed(bs_out));
endmodule
`default_nettype wire

// ==== jtag_tester.sv ====
// tester model driving the test port pins
`default_nettype none
module jtag_tester (
  output var logic tck,    // test clock
  output var logic tms,    // mode select
  output var logic tms_oe, // tms driven
  output var logic tdi,    // serial data
  output var logic tdi_oe, // tdi driven
  input wire logic tdo     // serial out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic q; // tdo seen before the last rise
  initial {tck, tms, tms_oe, tdi, tdi_oe} = 5'h0D;
  // one clock period, idle low between calls; released lines show a moving pattern
  task automatic step(input logic ms, input logic di, input logic fl = 1'h0);
    {tms_oe, tdi_oe} = {2{~fl}};
    tms = fl ? ~tms : ms;
    tdi = fl ? ~tdi : di;
    #32;
    q = tdo;
    tck = 1'h1;
    #32;
    tck = 1'h0;
  endtask
endmodule
`default_nettype wire

// ==== test_sram_boundary_scan_tap.sv ====
// self-checking bench for the sram test access port
`default_nettype none
`include "tap_map.vh"
module test_sram_boundary_scan_tap;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0]  ID_V = 32'h0000_5A3C; // arbitrary identification value
  localparam logic [108:0] PAT  = {1'h1, {27{4'hC}}};
  logic         sys_clk = 1'h0;
  logic         rst     = 1'h1;
  logic [108:0] pad_in  = PAT; // pads held quiet over every capture
  logic [108:0] o;
  wire          tck, tms, tms_oe, tdi, tdi_oe, tdo, tdo_oe, outputs_hiz, extest_en;
  wire  [108:0] bs_out;
  wire  [3:0]   tap_state;
  int           error_cnt = 0;
  int           total_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  jtag_tester tst (.tck, .tms, .tms_oe, .tdi, .tdi_oe, .tdo);
  sram_boundary_scan_tap #(.ID_VALUE(ID_V)) dut_u (.sys_clk, .rst, .tck, .tms, .tms_oe, .tdi,
    .tdi_oe, .tdo, .tdo_oe, .pad_in, .bs_out, .outputs_hiz, .extest_en, .tap_state);
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [108:0] g, input logic [108:0] e);
    total_checks++;
    error_cnt += int'(g !== e);
    if (g !== e) $display("MISMATCH %0t got %h exp %h", $time, g, e);
  endtask
  // from idle: walk to shift, move n bits lsb first, update, back to idle; n of zero moves one bit and stops in pause
  task automatic sh(input logic is_ir, input int n, input logic [108:0] v);
    o = '0;
    for (int i = is_ir ? 0 : 1; i < 4; i++)
      tst.step(i < 2, 1'h0);
    for (int i = 0; i < n; i++)
    begin
      tst.step(i == n - 1, v[i]);
      o[i] = tst.q;
    end
    tst.step(1'h1, 1'h0);
    tst.step(1'h0, 1'h0);
  endtask
  task automatic do_rst;
    if (rst !== 1'h1) @(negedge sys_clk);
    rst = 1'h1;
    repeat (2) @(negedge sys_clk);
    rst = 1'h0;
    chk(tap_state, `ST_TLR);
    chk(tdo_oe, 1'h0);
    tst.step(1'h0, 1'h0);
    sh(1'h0, 32, '0);
    chk(o, ID_V);
  endtask
  task automatic s_byp(input logic [2:0] k);
    sh(1'h1, 3, {106'h0, k});
    chk(o, `IR_CAPTURE_PAT);
    sh(1'h0, 4, 109'hB);
    chk(o, 109'h6);
  endtask
  task automatic s_pads;
    sh(1'h1, 3, `IR_SAMPLE);
    sh(1'h0, 109, ~PAT);
    chk(o, PAT);
    chk(bs_out, ~PAT);
    sh(1'h1, 3, `IR_SAMPLE_Z);
    chk(outputs_hiz, 1'h1);
    sh(1'h1, 3, `IR_EXTEST);
    chk({outputs_hiz, extest_en}, 2'h1);
  endtask
  task automatic s_five;
    sh(1'h0, 0, '0);
    repeat (5) tst.step(1'h0, 1'h0, 1'h1);
    chk(tap_state, `ST_TLR);
    chk({outputs_hiz, extest_en}, 2'h0);
    tst.step(1'h0, 1'h0);
    sh(1'h0, 32, '0);
    chk(o, ID_V);
  endtask
  initial
  begin
    do_rst();
    s_byp(`IR_BYPASS);
    s_byp(3'h5);
    s_pads();
    s_five();
    do_rst();
    finish_test();
  end
endmodule
bind sram_boundary_scan_tap tap_checker chk_u (.sys_clk, .rst, .tck, .tdo, .tdo_oe,
  .bs_out, .outputs_hiz, .tap_state);
`default_nettype wire
